// ===== bench/gpio_port_bank_test.sv
`timescale 1ns/1ns
`default_nettype none
module gpio_port_bank_test;
  import gpio_pkg::*;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic [15:0]         isa_addr = 16'h0000;
  logic [7:0]          isa_wd = 8'h00;
  logic                ior_n = 1'b1;
  logic                iow_n = 1'b1;
  logic                run_en = 1'b0;
  logic [1:0]          idx_sel = 2'h3;
  logic                cfg_state = 1'b0;
  logic                cfg_we = 1'b0;
  logic                cfg_re = 1'b0;
  logic [7:0]          cfg_addr = 8'h00;
  logic [7:0]          cfg_wdata = 8'h00;
  logic [1:0]          deb_en = 2'h0;
  logic [NUM_PINS-1:0] alt_out = 24'h000000;
  logic [NUM_PINS-1:0] alt_oe = 24'h000000;
  logic [NUM_PINS-1:0] ext_lvl = 24'h000000;
  logic [7:0]          isa_rd;
  logic                isa_oe;
  logic [7:0]          cfg_rdata;
  logic [NUM_PINS-1:0] gpio_out;
  logic [NUM_PINS-1:0] gpio_oe;
  logic [NUM_PINS-1:0] gpio_in;
  logic [NUM_PINS-1:0] alt_in;
  logic [NUM_PINS-1:0] edge_in;
  logic [1:0]          group_irq;
  logic [7:0]          v;
  logic                oe;
  int                  failures = 0;
  int                  checks = 0;
  int                  cycles = 0;

  gpio_port_bank #(.REJECT_CYCLES(400)) dut (
    .i_clk(clk), .i_rst(rst), .i_isa_addr(isa_addr), .i_isa_d(isa_wd),
    .i_isa_ior_n(ior_n), .i_isa_iow_n(iow_n), .o_isa_d(isa_rd), .o_isa_d_oe(isa_oe),
    .i_global_run_en(run_en), .i_index_sel(idx_sel), .i_cfg_state(cfg_state),
    .i_cfg_wr(cfg_we), .i_cfg_rd(cfg_re), .i_cfg_addr(cfg_addr),
    .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata), .i_debounce_en(deb_en),
    .i_gpio_in(gpio_in), .o_gpio_out(gpio_out), .o_gpio_oe(gpio_oe),
    .i_alt_out(alt_out), .i_alt_oe(alt_oe), .o_alt_in(alt_in),
    .o_either_edge_irq_input(edge_in), .o_group_irq(group_irq)
  );

  pin_model pins (
    .i_out(gpio_out), .i_oe(gpio_oe), .i_ext(ext_lvl), .o_level(gpio_in)
  );

  always #5 clk = ~clk;

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      test_done();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_we = 1'b1;
    tick(1);
    cfg_we = 1'b0;
    tick(3);
  endtask : cfg_write

  task automatic cfg_read(input logic [7:0] a, output logic [7:0] d);
    cfg_addr = a;
    cfg_re = 1'b1;
    tick(1);
    cfg_re = 1'b0;
    d = cfg_rdata;
  endtask : cfg_read

  task automatic isa_write(input logic [15:0] a, input logic [7:0] d);
    isa_addr = a;
    isa_wd = d;
    iow_n = 1'b0;
    tick(4);
    iow_n = 1'b1;
    tick(5);
  endtask : isa_write

  task automatic isa_read(input logic [15:0] a, output logic [7:0] d, output logic e);
    isa_addr = a;
    ior_n = 1'b0;
    tick(5);
    d = isa_rd;
    e = isa_oe;
    ior_n = 1'b1;
    tick(5);
  endtask : isa_read

  initial
  begin
    tick(6);
    rst = 1'b0;
    tick(4);
    check(gpio_oe, PIN_EXISTS, "oe after reset");
    check(gpio_out, 24'h000000, "out after reset");
    check(alt_in, ALT_IN_IDLE, "alt inputs idle");
    check({22'h0, group_irq}, 24'h000000, "irq idle");
    $display("test reset done");
    cfg_write(CFG_PIN_ONE_BASE, 8'h01);
    check(gpio_oe, PIN_EXISTS, "cfg outside state");
    cfg_state = 1'b1;
    cfg_write(CFG_PIN_ONE_BASE, 8'h01);
    cfg_read(CFG_PIN_ONE_BASE, v);
    check({16'h0, v}, 24'h000001, "cfg readback");
    check({23'h0, gpio_oe[0]}, 24'h000000, "input not driven");
    $display("test config done");
    ext_lvl = 24'h000001;
    tick(4);
    cfg_read(CFG_PORT_ONE_DATA, v);
    check({16'h0, v}, 24'h000001, "input read");
    cfg_write(CFG_PIN_ONE_BASE, 8'h03);
    cfg_read(CFG_PORT_ONE_DATA, v);
    check({16'h0, v}, 24'h000000, "inverted input read");
    cfg_write(CFG_PORT_ONE_DATA, 8'hff);
    cfg_read(CFG_PORT_ONE_DATA, v);
    check({16'h0, v}, 24'h0000fe, "input write dropped");
    check({17'h0, gpio_out[7:1]}, 24'h00007f, "outputs follow data");
    cfg_write(CFG_PIN_ONE_BASE, 8'h00);
    cfg_read(CFG_PORT_ONE_DATA, v);
    check({16'h0, v}, 24'h0000fe, "output read last write");
    cfg_write(CFG_PIN_ONE_BASE + 8'h01, 8'h02);
    check({23'h0, gpio_out[1]}, 24'h000000, "inverted output");
    $display("test data done");
    cfg_write(CFG_PIN_ONE_BASE + 8'h02, 8'h80);
    check({23'h0, gpio_oe[2]}, 24'h000000, "open drain high released");
    cfg_write(CFG_PORT_ONE_DATA, 8'hfb);
    check({22'h0, gpio_oe[2], gpio_out[2]}, 24'h000002, "open drain low");
    $display("test drive done");
    alt_out = 24'h000008;
    alt_oe = 24'h000008;
    ext_lvl = 24'h000011;
    cfg_write(CFG_PIN_ONE_BASE + 8'h03, 8'h08);
    check({22'h0, gpio_oe[3], gpio_out[3]}, 24'h000003, "alt output");
    cfg_write(CFG_PIN_ONE_BASE + 8'h03, 8'h0a);
    check({23'h0, gpio_out[3]}, 24'h000000, "alt output inverted");
    cfg_write(CFG_PIN_ONE_BASE + 8'h04, 8'h0a);
    check({22'h0, gpio_oe[4], alt_in[4]}, 24'h000001, "alt input");
    check({23'h0, edge_in[4]}, 24'h000000, "edge input inverted");
    cfg_write(CFG_PIN_ONE_BASE + 8'h04, 8'h08);
    check({23'h0, edge_in[4]}, 24'h000001, "edge input plain");
    $display("test alternate done");
    cfg_write(CFG_PIN_ONE_BASE + 8'h05, 8'h20);
    check({22'h0, group_irq}, 24'h000001, "output raises irq");
    cfg_write(CFG_PORT_ONE_DATA, 8'hdb);
    check({22'h0, group_irq}, 24'h000000, "output clears irq");
    cfg_write(CFG_PIN_SIX_BASE, 8'h21);
    ext_lvl[16] = 1'b1;
    tick(5);
    check({22'h0, group_irq}, 24'h000002, "input raises irq");
    ext_lvl[16] = 1'b0;
    deb_en = 2'h2;
    tick(450);
    ext_lvl[16] = 1'b1;
    tick(300);
    ext_lvl[16] = 1'b0;
    tick(5);
    check({22'h0, group_irq}, 24'h000000, "short pulse rejected");
    tick(450);
    ext_lvl[16] = 1'b1;
    tick(380);
    check({22'h0, group_irq}, 24'h000000, "filter still counting");
    tick(60);
    check({22'h0, group_irq}, 24'h000002, "long level passed");
    $display("test irq done");
    isa_write(16'h00ea, IDX_PORT_SIX);
    isa_read(16'h00eb, v, oe);
    check({23'h0, oe}, 24'h000000, "run access disabled");
    run_en = 1'b1;
    isa_write(16'h00ea, IDX_PORT_SIX);
    isa_write(16'h00eb, 8'h5a);
    check({17'h0, gpio_out[23:17]}, 24'h00002d, "port six driven");
    isa_read(16'h00eb, v, oe);
    check({15'h0, oe, v}, 24'h00015b, "port six read");
    cfg_read(CFG_PORT_SIX_DATA, v);
    check({16'h0, v}, 24'h00005b, "port six config read");
    isa_write(16'h00ea, IDX_PORT_FIVE);
    isa_write(16'h00eb, 8'hff);
    isa_read(16'h00eb, v, oe);
    check({15'h0, oe, v}, {15'h0, 1'b1, PORT_FIVE_MASK}, "port five read");
    isa_write(16'h00ea, 8'h03);
    isa_read(16'h00eb, v, oe);
    check({23'h0, oe}, 24'h000000, "unmapped index");
    idx_sel = 2'h0;
    isa_write(INDEX_BASE_E0, IDX_PORT_ONE);
    ext_lvl[0] = 1'b0;
    cfg_write(CFG_PIN_ONE_BASE, 8'h01);
    isa_read(INDEX_BASE_E0 + 16'h0001, v, oe);
    check({15'h0, oe, v}, 24'h0001da, "moved data port");
    idx_sel = 2'h1;
    isa_write(INDEX_BASE_E2, IDX_PORT_ONE);
    isa_read(INDEX_BASE_E2 + 16'h0001, v, oe);
    check({23'h0, oe}, 24'h000001, "data port at second base");
    idx_sel = 2'h2;
    isa_write(INDEX_BASE_E4, IDX_PORT_ONE);
    isa_read(INDEX_BASE_E4 + 16'h0001, v, oe);
    check({23'h0, oe}, 24'h000001, "data port at third base");
    isa_read(16'h00eb, v, oe);
    check({23'h0, oe}, 24'h000000, "old data port");
    $display("test bus done");
    test_done();
  end
endmodule : gpio_port_bank_test
`default_nettype wire

// ===== bench/pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module pin_model
  import gpio_pkg::*;
(
  input  wire logic [NUM_PINS-1:0] i_out,
  input  wire logic [NUM_PINS-1:0] i_oe,
  input  wire logic [NUM_PINS-1:0] i_ext,
  output logic      [NUM_PINS-1:0] o_level
);
  // Level of a driven or released pin.
  // A switch with a pull-up sets the level while the bank does not drive.
  assign o_level = (i_oe & i_out) | (~i_oe & i_ext);
endmodule : pin_model
`default_nettype wire

// ===== common/gpio_pkg.sv
package gpio_pkg;

  localparam int unsigned NUM_PINS = 24;
  localparam int unsigned NUM_PORTS = 3;

  // Run-state index values of the data registers.
  localparam logic [7:0] IDX_PORT_ONE  = 8'h01;
  localparam logic [7:0] IDX_PORT_FIVE = 8'h05;
  localparam logic [7:0] IDX_PORT_SIX  = 8'h06;

  // Configuration-state addresses of the data and per-pin registers.
  localparam logic [7:0] CFG_PORT_ONE_DATA  = 8'hf6;
  localparam logic [7:0] CFG_PORT_FIVE_DATA = 8'hf9;
  localparam logic [7:0] CFG_PORT_SIX_DATA  = 8'hfa;
  localparam logic [7:0] CFG_PIN_ONE_BASE   = 8'he0;
  localparam logic [7:0] CFG_PIN_FIVE_BASE  = 8'hc8;
  localparam logic [7:0] CFG_PIN_SIX_BASE   = 8'hd0;

  // Fields of a pin configuration register.
  localparam int unsigned CFG_DIR    = 0;
  localparam int unsigned CFG_POL    = 1;
  localparam int unsigned CFG_FN_LO  = 3;
  localparam int unsigned CFG_FN_HI  = 4;
  localparam int unsigned CFG_IRQ_EN = 5;
  localparam int unsigned CFG_OD     = 7;
  localparam logic [1:0]  FN_GPIO    = 2'h0;

  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [7:0]  DATA_RESET = 8'h00;
  localparam logic [7:0]  INDEX_RESET = 8'h00;

  // Port five only has bits 0, 2, 3 and 4.
  localparam logic [7:0]  PORT_FIVE_MASK = 8'h1d;
  localparam logic [NUM_PINS-1:0] PIN_EXISTS = 24'hff1dff;
  localparam logic [NUM_PINS-1:0] ALT_IN_IDLE = 24'hffffff;
  localparam logic [NUM_PINS-1:0] GROUP_TWO_PINS = 24'hffff00;

  // Index port bases; the data port is the base plus one.
  localparam logic [15:0] INDEX_BASE_E0 = 16'h00e0;
  localparam logic [15:0] INDEX_BASE_E2 = 16'h00e2;
  localparam logic [15:0] INDEX_BASE_E4 = 16'h00e4;
  localparam logic [15:0] INDEX_BASE_EA = 16'h00ea;

  // Debounce timing.
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned REJECT_TIME_US = 1000;
  localparam int unsigned REJECT_CYCLES_DEF = REJECT_TIME_US * CLK_MHZ;
  localparam int unsigned REJECT_TICKS   = 100;
  localparam int unsigned TICK_CNT_W     = 7;

  // Maps a run-state index to a port number; bit 2 flags a hit.
  function automatic logic [2:0] run_index_port(input logic [7:0] idx);
    unique case (idx)
      IDX_PORT_ONE:  run_index_port = 3'h4;
      IDX_PORT_FIVE: run_index_port = 3'h5;
      IDX_PORT_SIX:  run_index_port = 3'h6;
      default:       run_index_port = 3'h0;
    endcase
  endfunction : run_index_port

  // Maps a configuration address to a data port; bit 2 flags a hit.
  function automatic logic [2:0] cfg_data_port(input logic [7:0] addr);
    unique case (addr)
      CFG_PORT_ONE_DATA:  cfg_data_port = 3'h4;
      CFG_PORT_FIVE_DATA: cfg_data_port = 3'h5;
      CFG_PORT_SIX_DATA:  cfg_data_port = 3'h6;
      default:            cfg_data_port = 3'h0;
    endcase
  endfunction : cfg_data_port

  // Maps a configuration address to a pin; bit 5 flags a hit.
  function automatic logic [5:0] cfg_pin(input logic [7:0] addr);
    logic [4:0] p;
    p = 5'h00;
    if (addr[7:3] == CFG_PIN_ONE_BASE[7:3])
      p = {2'h0, addr[2:0]};
    else if (addr[7:3] == CFG_PIN_FIVE_BASE[7:3])
      p = {2'h1, addr[2:0]};
    else if (addr[7:3] == CFG_PIN_SIX_BASE[7:3])
      p = {2'h2, addr[2:0]};
    else
      return 6'h00;
    return {PIN_EXISTS[p], p};
  endfunction : cfg_pin

  // Maps the index base select to the index port address.
  function automatic logic [15:0] index_port_base(input logic [1:0] sel);
    unique case (sel)
      2'h0: index_port_base = INDEX_BASE_E0;
      2'h1: index_port_base = INDEX_BASE_E2;
      2'h2: index_port_base = INDEX_BASE_E4;
      2'h3: index_port_base = INDEX_BASE_EA;
    endcase
  endfunction : index_port_base

endpackage : gpio_pkg

// ===== src/debounce_filter.sv
`timescale 1ns/1ns
`default_nettype none
module debounce_filter
  import gpio_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_tick,
  input  wire logic i_raw,
  output logic      o_clean
);

  logic [TICK_CNT_W-1:0] cnt_ff;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_ff  <= '0;
      o_clean <= 1'b0;
    end
    else if (i_raw == o_clean)
      cnt_ff <= '0;
    else if (i_tick)
    begin
      if (cnt_ff == TICK_CNT_W'(REJECT_TICKS))
      begin
        o_clean <= i_raw;
        cnt_ff  <= '0;
      end
      else
        cnt_ff <= cnt_ff + 1'b1;
    end
  end

  a_short_reject: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(o_clean) |-> $past(i_tick) && $past(cnt_ff) == TICK_CNT_W'(REJECT_TICKS))
    else $error("Filter output changed before the reject limit.");

  c_filter_pass: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_clean));

endmodule : debounce_filter
`default_nettype wire

// ===== src/gpio_port_bank.sv
// What this block does
// - Indexes 01, 05, 06 select the port data.
// - Pin configuration reachable only in configuration state.
// - Config bit 0: one input, zero output.
// - Config bit 1 inverts pin/data path.
// - Config bits 4:3 select pin function.
// - Config bit 5 enables group interrupt.
// - Config bit 7 picks output drive type.
// - Alternate function overrides direction bit.
// - Alternate outputs invert; inputs not, except edge.
// - Group interrupt ORs enabled pins, active high.
// - Groups one and two feed system events.
// - Per-group debounce rejects pulses up to 1ms.
// - Unselected alternate inputs read inactive.
// - Input read returns captured pin with polarity.
// - Writes to input bits have no effect.
// - Output pin drives written value, polarity applied.
// - Output read returns last written value.
// - Enabled outputs still feed group interrupt.
// - Run access needs global enable bit seven.
// - Index port default EA, data at plus one.
`timescale 1ns/1ns
`default_nettype none
module gpio_port_bank
  import gpio_pkg::*;
#(
  parameter int unsigned REJECT_CYCLES = REJECT_CYCLES_DEF
)
(
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic [15:0]         i_isa_addr,
  input  wire logic [7:0]          i_isa_d,
  input  wire logic                i_isa_ior_n,
  input  wire logic                i_isa_iow_n,
  output logic      [7:0]          o_isa_d,
  output logic                     o_isa_d_oe,
  input  wire logic                i_global_run_en,
  input  wire logic [1:0]          i_index_sel,
  input  wire logic                i_cfg_state,
  input  wire logic                i_cfg_wr,
  input  wire logic                i_cfg_rd,
  input  wire logic [7:0]          i_cfg_addr,
  input  wire logic [7:0]          i_cfg_wdata,
  output logic      [7:0]          o_cfg_rdata,
  input  wire logic [1:0]          i_debounce_en,
  input  wire logic [NUM_PINS-1:0] i_gpio_in,
  output logic      [NUM_PINS-1:0] o_gpio_out,
  output logic      [NUM_PINS-1:0] o_gpio_oe,
  input  wire logic [NUM_PINS-1:0] i_alt_out,
  input  wire logic [NUM_PINS-1:0] i_alt_oe,
  output logic      [NUM_PINS-1:0] o_alt_in,
  output logic      [NUM_PINS-1:0] o_either_edge_irq_input,
  output logic      [1:0]          o_group_irq
);

  localparam int unsigned TICK_DIV = REJECT_CYCLES / REJECT_TICKS;
  localparam int unsigned DIV_W = $clog2(TICK_DIV + 1);

  logic [15:0]         addr_s1_ff, addr_s2_ff;
  logic [7:0]          d_s1_ff, d_s2_ff;
  logic [1:0]          ior_s_ff, iow_s_ff;
  logic                iow_prev_ff;
  logic [NUM_PINS-1:0] pin_s1_ff, pin_s2_ff;
  logic [7:0]          cfg_ff [NUM_PINS];
  logic [NUM_PINS-1:0] data_ff;
  logic [7:0]          index_ff;
  logic [DIV_W-1:0]    div_ff;
  logic                tick_ff;
  logic [15:0]         index_addr;
  logic                run_wr, run_rd, idx_hit, dat_hit;
  logic [2:0]          run_port, cfgd_port;
  logic [5:0]          cfg_pin_hit;
  logic [NUM_PINS-1:0] dir_in, pol, alt, od, irq_en, rd_vec;
  logic [NUM_PINS-1:0] drv_val, drv_dir, clean, irq_src;
  logic [NUM_PINS-1:0] nxt_out, nxt_oe, wr_val;
  logic                data_we;
  logic [1:0]          data_we_port;

  // Two flip-flops on every pin and bus input.
  always_ff @(posedge i_clk)
  begin
    addr_s1_ff <= i_isa_addr;
    addr_s2_ff <= addr_s1_ff;
    d_s1_ff    <= i_isa_d;
    d_s2_ff    <= d_s1_ff;
    pin_s1_ff  <= i_gpio_in;
    pin_s2_ff  <= pin_s1_ff;
    if (i_rst)
    begin
      ior_s_ff    <= 2'h3;
      iow_s_ff    <= 2'h3;
      iow_prev_ff <= 1'b1;
    end
    else
    begin
      ior_s_ff    <= {ior_s_ff[0], i_isa_ior_n};
      iow_s_ff    <= {iow_s_ff[0], i_isa_iow_n};
      iow_prev_ff <= iow_s_ff[1];
    end
  end

  assign index_addr = index_port_base(i_index_sel);

  assign run_wr = i_global_run_en && iow_s_ff[1] && !iow_prev_ff;
  assign run_rd = i_global_run_en && !ior_s_ff[1];
  assign idx_hit = addr_s2_ff == index_addr;
  assign dat_hit = addr_s2_ff == index_addr + 16'h0001;
  assign run_port = run_index_port(index_ff);
  assign cfgd_port = cfg_data_port(i_cfg_addr);
  assign cfg_pin_hit = cfg_pin(i_cfg_addr);

  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      dir_in[i] = cfg_ff[i][CFG_DIR];
      pol[i]    = cfg_ff[i][CFG_POL];
      alt[i]    = cfg_ff[i][CFG_FN_HI:CFG_FN_LO] != FN_GPIO;
      od[i]     = cfg_ff[i][CFG_OD];
      irq_en[i] = cfg_ff[i][CFG_IRQ_EN];
    end
  end

  // Input bits read the pin with polarity.
  // Output bits read the last write.
  assign rd_vec = PIN_EXISTS & ((dir_in & (pin_s2_ff ^ pol)) | (~dir_in & data_ff));
  assign data_we = (run_wr && dat_hit && run_port[2])
                || (i_cfg_wr && cfgd_port[2]);
  assign data_we_port = (run_wr && dat_hit) ? run_port[1:0] : cfgd_port[1:0];

  always_comb
  begin
    wr_val = data_ff;
    for (int b = 0; b < 8; b++)
      if (!dir_in[{data_we_port, 3'(b)}])
        wr_val[{data_we_port, 3'(b)}] = (run_wr && dat_hit) ? d_s2_ff[b] : i_cfg_wdata[b];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      data_ff <= {NUM_PINS{1'b0}};
    else if (data_we)
      data_ff <= wr_val & PIN_EXISTS;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      index_ff <= INDEX_RESET;
    else if (run_wr && idx_hit)
      index_ff <= d_s2_ff;
  end

  // Pin configuration writes only in configuration state.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < NUM_PINS; i++)
        cfg_ff[i] <= CFG_RESET;
    end
    else if (i_cfg_wr && i_cfg_state && cfg_pin_hit[5])
      cfg_ff[cfg_pin_hit[4:0]] <= i_cfg_wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_cfg_rdata <= 8'h00;
    else if (i_cfg_rd && i_cfg_state && cfg_pin_hit[5])
      o_cfg_rdata <= cfg_ff[cfg_pin_hit[4:0]];
    else if (i_cfg_rd && cfgd_port[2])
      o_cfg_rdata <= rd_vec[{cfgd_port[1:0], 3'h0} +: 8];
    else if (i_cfg_rd)
      o_cfg_rdata <= 8'h00;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_isa_d    <= 8'h00;
      o_isa_d_oe <= 1'b0;
    end
    else
    begin
      o_isa_d_oe <= run_rd && (idx_hit || (dat_hit && run_port[2]));
      if (run_rd && idx_hit)
        o_isa_d <= index_ff;
      else if (run_rd && dat_hit && run_port[2])
        o_isa_d <= rd_vec[{run_port[1:0], 3'h0} +: 8];
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      drv_dir[i] = alt[i] ? i_alt_oe[i] : !dir_in[i];
      drv_val[i] = (alt[i] ? i_alt_out[i] : data_ff[i]) ^ pol[i];
      nxt_out[i] = od[i] ? 1'b0 : drv_val[i];
      nxt_oe[i]  = PIN_EXISTS[i] && drv_dir[i] && (!od[i] || !drv_val[i]);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_gpio_out <= {NUM_PINS{1'b0}};
      o_gpio_oe  <= {NUM_PINS{1'b0}};
    end
    else
    begin
      o_gpio_out <= nxt_out;
      o_gpio_oe  <= nxt_oe;
    end
  end

  // Alternate inputs stay plain; edge input follows polarity.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_alt_in                <= ALT_IN_IDLE;
      o_either_edge_irq_input <= {NUM_PINS{1'b0}};
    end
    else
    begin
      o_alt_in                <= (alt & pin_s2_ff) | (~alt & ALT_IN_IDLE);
      o_either_edge_irq_input <= alt & (pin_s2_ff ^ pol);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= div_ff == DIV_W'(TICK_DIV - 1);
      div_ff  <= (div_ff == DIV_W'(TICK_DIV - 1)) ? '0 : div_ff + 1'b1;
    end
  end

  for (genvar g = 0; g < NUM_PINS; g++)
  begin : g_filt
    debounce_filter u_filt (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_tick  (tick_ff),
      .i_raw   (pin_s2_ff[g] ^ pol[g]),
      .o_clean (clean[g])
    );
  end

  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      // Filtered level when group debounce is on.
      if (!drv_dir[i])
        irq_src[i] = i_debounce_en[GROUP_TWO_PINS[i]] ? clean[i] : pin_s2_ff[i] ^ pol[i];
      else
        irq_src[i] = drv_val[i];
    end
  end

  // Group outputs also serve system events.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_group_irq <= 2'h0;
    else
    begin
      o_group_irq[0] <= |(irq_src & irq_en & PIN_EXISTS & ~GROUP_TWO_PINS);
      o_group_irq[1] <= |(irq_src & irq_en & PIN_EXISTS & GROUP_TWO_PINS);
    end
  end

  a_cfg_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_cfg_state |=> $stable(cfg_ff[0]))
    else $error("Pin configuration changed outside configuration state.");
  a_input_wr_ignored: assert property (@(posedge i_clk) disable iff (i_rst)
    data_we |=> ((data_ff ^ $past(data_ff)) & $past(dir_in)) == '0)
    else $error("Write changed an input bit.");
  a_push_pull_out: assert property (@(posedge i_clk) disable iff (i_rst)
    !alt[0] && !dir_in[0] && !od[0] |=> o_gpio_oe[0] && o_gpio_out[0] == $past(drv_val[0]))
    else $error("Output pin does not drive data with polarity.");
  a_open_drain: assert property (@(posedge i_clk) disable iff (i_rst)
    od[0] |=> !o_gpio_out[0] && (o_gpio_oe[0] == ($past(drv_dir[0]) && !$past(drv_val[0]))))
    else $error("Open-drain pin driven high.");
  a_alt_direction: assert property (@(posedge i_clk) disable iff (i_rst)
    alt[0] && !od[0] |=> o_gpio_oe[0] == $past(i_alt_oe[0]))
    else $error("Alternate direction not applied.");
  a_alt_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    !alt[0] |=> o_alt_in[0] == ALT_IN_IDLE[0])
    else $error("Unselected alternate input not idle.");
  a_run_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_global_run_en |=> !o_isa_d_oe)
    else $error("Data port answered while run access disabled.");
  a_irq_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    (irq_en & PIN_EXISTS) == '0 |=> o_group_irq == 2'h0)
    else $error("Group interrupt without enabled pin.");
  a_input_read: assert property (@(posedge i_clk) disable iff (i_rst)
    run_rd && dat_hit && run_port == 3'h4 && dir_in[0] |=> o_isa_d[0] == $past(pin_s2_ff[0] ^ pol[0]))
    else $error("Input read does not return the pin level.");

  c_run_read: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_isa_d_oe));
  c_irq_one: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_group_irq[0]));
  c_irq_two: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_group_irq[1]));

endmodule : gpio_port_bank
`default_nettype wire
